/* hw/ilw_link_write.sv */
// Write-transfer flow control for one serial inter-processor link.
// Assumes an APB master on pclk and a link serialiser that sends one frame
// per start pulse and reports acknowledgements, triggers and peer activity.
//
// Summary of operation
// - Only one initiator and one unacknowledged write frame exist at any time.
// - A write request bit of one starts a write frame on that channel.
// - A streaming request bit of one starts a streaming write on that channel.
// - A start while an acknowledgement is pending sets the channel timeout error flag.
// - Overlapping starts could corrupt the last byte of the earlier frame.
// - No write starts while the peer's own write transfer is in progress.
// - With write ack interrupt enable set, an acknowledgement raises an interrupt; irq here also needs the channel's ack bit set in the interrupt mask.
// - Token passes by trigger: write then trigger after ack, else return at once.
// - A transfer starts only while this end holds the token.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module ilw_link_write (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_ack_in,
    input wire logic link_trig_in,
    input wire logic link_peer_busy_in,
    output logic link_start,
    output ilw_pkg::ilw_frame_t link_frame,
    output logic irq
);
    import ilw_pkg::*;

    // ==========================================================
    // Declarations
    logic pready_ff, pslverr_ff, link_start_ff, irq_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_rdata;
    logic nxt_err;
    ilw_frame_t link_frame_ff;
    ilw_state_t state_ff;
    logic pend_vld_ff, token_ff, token_en_ff, pass_ff;
    ilw_frame_kind_t pend_kind_ff;
    logic [CHW-1:0] pend_ch_ff, act_ch_ff;
    logic [NUM_CH-1:0] ack_rcv_ff, toe_ff, write_ack_irq_enable_ff;
    logic [2*NUM_CH-1:0] ist_ff, imask_ff;
    logic [TMRW-1:0] tmr_ff;
    logic [2:0] lvl_s, rise_s;
    logic acc, wr_acc, wr_cmd, busy, may_go, send_trig, start_wr, ack_hit, tmo_hit;
    logic [NUM_CH-1:0] wreq, sreq, req, acc_mask, rej;
    logic [CHW-1:0] acc_ch;

    // ==========================================================
    // Link input synchronisers
    ilw_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({link_peer_busy_in, link_trig_in, link_ack_in}),
        .level_out(lvl_s),
        .rise_out(rise_s)
    );

    // ==========================================================
    // APB slave: one wait state, answer registered at the ready edge.
    assign acc = psel & penable & pready_ff;
    assign wr_acc = acc & pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            prdata_ff <= (psel & penable & ~pready_ff & ~pwrite) ? nxt_rdata : 32'h0000_0000;
            pslverr_ff <= psel & penable & ~pready_ff & nxt_err;
        end
    end

    // Read data and the unmapped-address error.
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        case (paddr)
            OFF_CMD: nxt_rdata = 32'h0000_0000;
            OFF_STATUS: begin
                nxt_rdata[STA_ACK_LSB +: NUM_CH] = ack_rcv_ff;
                nxt_rdata[STA_BUSY_BIT] = (state_ff == ST_WAIT_ACK);
                nxt_rdata[STA_TOKEN_BIT] = token_ff;
                nxt_rdata[STA_PEND_BIT] = pend_vld_ff;
                nxt_rdata[STA_CH_LSB +: CHW] = act_ch_ff;
            end
            OFF_ERR: nxt_rdata[NUM_CH-1:0] = toe_ff;
            OFF_CTRL: begin
                nxt_rdata[CTRL_WRITE_ACK_IRQ_ENABLE_LSB +: NUM_CH] = write_ack_irq_enable_ff;
                nxt_rdata[CTRL_TOKEN_EN_BIT] = token_en_ff;
            end
            OFF_IRQ_STAT: nxt_rdata[2*NUM_CH-1:0] = ist_ff;
            OFF_IRQ_MASK: nxt_rdata[2*NUM_CH-1:0] = imask_ff;
            default: nxt_err = 1'b1;
        endcase
    end

    // ==========================================================
    // Command decode: accept the lowest request when free, refuse the rest.
    assign wr_cmd = wr_acc & (paddr == OFF_CMD);
    assign wreq = wr_cmd ? pwdata[CMD_WRT_LSB +: NUM_CH] : '0;
    assign sreq = wr_cmd ? pwdata[CMD_STR_LSB +: NUM_CH] : '0;
    assign req = wreq | sreq;
    assign busy = pend_vld_ff | (state_ff == ST_WAIT_ACK);
    assign acc_mask = busy ? '0 : (req & (~req + 1'b1));
    // Refusing an overlapped start keeps the earlier frame's last byte intact.
    assign rej = req & ~acc_mask;
    always_comb begin
        acc_ch = '0;
        for (int c = NUM_CH - 1; c >= 0; c--) begin
            if (acc_mask[c]) begin
                acc_ch = CHW'(c);
            end
        end
    end

    // ==========================================================
    // Start and token decisions in idle, ack and timeout detection while waiting for the ack.
    assign may_go = ~lvl_s[2] & (~token_en_ff | token_ff);
    assign send_trig = (state_ff == ST_IDLE) & token_en_ff & token_ff & (pass_ff | ~pend_vld_ff);
    assign start_wr = (state_ff == ST_IDLE) & pend_vld_ff & may_go & ~send_trig;
    assign ack_hit = (state_ff == ST_WAIT_ACK) & rise_s[0];
    assign tmo_hit = (state_ff == ST_WAIT_ACK) & ~rise_s[0] & (tmr_ff == '0);

    // Pending request holder; one request at most.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_vld_ff <= 1'b0;
            pend_kind_ff <= FRM_WRITE;
            pend_ch_ff <= '0;
        end else if (start_wr) begin
            pend_vld_ff <= 1'b0;
        end else if (|acc_mask) begin
            pend_vld_ff <= 1'b1;
            pend_kind_ff <= (|(wreq & acc_mask)) ? FRM_WRITE : FRM_STREAM;
            pend_ch_ff <= acc_ch;
        end
    end

    // Transfer state machine and acknowledgement timer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            act_ch_ff <= '0;
            tmr_ff <= '0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start_wr) begin
                        state_ff <= ST_WAIT_ACK;
                        act_ch_ff <= pend_ch_ff;
                        tmr_ff <= TMRW'(ACK_TIMEOUT_CYC - 1);
                    end
                end
                ST_WAIT_ACK: begin
                    if (ack_hit || tmo_hit) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Token ownership: a received trigger grants it, a sent trigger gives it away.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            token_ff <= TOKEN_RST;
            pass_ff <= 1'b0;
        end else begin
            if (rise_s[1]) begin
                token_ff <= 1'b1;
            end else if (send_trig) begin
                token_ff <= 1'b0;
            end
            if (ack_hit || tmo_hit) begin
                pass_ff <= 1'b1;
            end else if (send_trig) begin
                pass_ff <= 1'b0;
            end
        end
    end

    // Frame start pulse toward the serialiser.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_start_ff <= 1'b0;
            link_frame_ff <= '0;
        end else begin
            link_start_ff <= start_wr | send_trig;
            if (start_wr) begin
                link_frame_ff.kind <= pend_kind_ff;
                link_frame_ff.chan <= pend_ch_ff;
            end else if (send_trig) begin
                link_frame_ff.kind <= FRM_TRIGGER;
                link_frame_ff.chan <= '0;
            end
        end
    end

    // ==========================================================
    // Status, error and interrupt registers; hardware set beats software clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_rcv_ff <= ACK_RCV_RST;
            toe_ff <= '0;
            ist_ff <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (ack_hit && act_ch_ff == CHW'(c)) begin
                    ack_rcv_ff[c] <= 1'b1;
                end else if (start_wr && pend_ch_ff == CHW'(c)) begin
                    ack_rcv_ff[c] <= 1'b0;
                end
                toe_ff[c] <= (toe_ff[c] & ~(wr_acc & (paddr == OFF_ERR) & pwdata[c]))
                    | rej[c] | (tmo_hit & (act_ch_ff == CHW'(c)));
                ist_ff[IST_ACK_LSB + c] <= (ist_ff[IST_ACK_LSB + c]
                    & ~(wr_acc & (paddr == OFF_IRQ_STAT) & pwdata[IST_ACK_LSB + c]))
                    | (ack_hit & (act_ch_ff == CHW'(c)) & write_ack_irq_enable_ff[c]);
                ist_ff[IST_TO_LSB + c] <= (ist_ff[IST_TO_LSB + c]
                    & ~(wr_acc & (paddr == OFF_IRQ_STAT) & pwdata[IST_TO_LSB + c]))
                    | rej[c] | (tmo_hit & (act_ch_ff == CHW'(c)));
            end
        end
    end

    // Software control and mask registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_ack_irq_enable_ff <= WRITE_ACK_IRQ_ENABLE_RST;
            token_en_ff <= TOKEN_EN_RST;
            imask_ff <= IRQ_MASK_RST;
        end else begin
            if (wr_acc && paddr == OFF_CTRL) begin
                write_ack_irq_enable_ff <= pwdata[CTRL_WRITE_ACK_IRQ_ENABLE_LSB +: NUM_CH];
                token_en_ff <= pwdata[CTRL_TOKEN_EN_BIT];
            end
            if (wr_acc && paddr == OFF_IRQ_MASK) begin
                imask_ff <= pwdata[2*NUM_CH-1:0];
            end
        end
    end

    // Level interrupt from unmasked sticky bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(ist_ff & imask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign link_start = link_start_ff;
    assign link_frame = link_frame_ff;
    assign irq = irq_ff;

    // ==========================================================
    // Assertions
    logic data_start;
    assign data_start = link_start_ff & (link_frame_ff.kind != FRM_TRIGGER);

    sequence ack_seen_s;
        ack_hit && write_ack_irq_enable_ff[act_ch_ff];
    endsequence
    sequence ack_irq_s;
        ##1 ist_ff[IST_ACK_LSB + $past(act_ch_ff)] ##1 (irq_ff || !imask_ff[IST_ACK_LSB + $past(act_ch_ff, 2)]);
    endsequence
    sequence trig_back_s;
        ##[1:3] (link_start_ff && link_frame_ff.kind == FRM_TRIGGER);
    endsequence

    single_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_WAIT_ACK) && $past(state_ff == ST_WAIT_ACK) |-> !data_start)
        else $error("Second data frame started while one is outstanding.");
    write_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_wr && pend_kind_ff == FRM_WRITE |=> link_start_ff && link_frame_ff.kind == FRM_WRITE)
        else $error("Write request did not start a write frame.");
    stream_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        data_start && link_frame_ff.kind == FRM_STREAM |-> $past(pend_kind_ff == FRM_STREAM))
        else $error("Streaming frame sent without a streaming request.");
    overlap_error_a: assert property (@(posedge pclk) disable iff (!presetn)
        |rej |=> (toe_ff & $past(rej)) == $past(rej) && !$past(|acc_mask & busy))
        else $error("Overlapped start did not set the timeout error flag.");
    peer_clash_a: assert property (@(posedge pclk) disable iff (!presetn)
        data_start |-> $past(!lvl_s[2]))
        else $error("Write started while the peer was transferring.");
    ack_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_seen_s |-> ack_irq_s)
        else $error("Write acknowledgement did not raise the interrupt.");
    token_return_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_hit && token_en_ff && token_ff && !rise_s[1] |-> trig_back_s)
        else $error("Token was not passed back after the acknowledgement.");
    token_held_a: assert property (@(posedge pclk) disable iff (!presetn)
        data_start && $past(token_en_ff) |-> $past(token_ff))
        else $error("Transfer started without holding the token.");
    ack_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        data_start |-> !ack_rcv_ff[link_frame_ff.chan] ##1 1'b1)
        else $error("Ack received flag not cleared by the new write.");
    ack_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_hit |=> ack_rcv_ff[$past(act_ch_ff)] && state_ff == ST_IDLE)
        else $error("Acknowledgement did not set the ack received flag.");
endmodule

/* hw/ilw_pkg.sv */
// Package for the link write flow block: register map, field positions,
// reset values, timing counts and the shared types.
// Assumes a single 250 MHz bus clock and a 32-bit APB register bus.
package ilw_pkg;
    // ==========================================================
    // Geometry and timing
    localparam int NUM_CH = 4;
    localparam int CHW = 2;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ACK_TIMEOUT_NS = 10000;
    // Longest wait for an acknowledgement, rounded down to whole cycles.
    localparam int ACK_TIMEOUT_CYC = (ACK_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    localparam int TMRW = 12;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_ERR = 12'h008;
    localparam logic [11:0] OFF_CTRL = 12'h00c;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h014;

    // ==========================================================
    // Field positions
    localparam int CMD_WRT_LSB = 0;
    localparam int CMD_STR_LSB = 4;
    localparam int STA_ACK_LSB = 0;
    localparam int STA_BUSY_BIT = 8;
    localparam int STA_TOKEN_BIT = 9;
    localparam int STA_PEND_BIT = 10;
    localparam int STA_CH_LSB = 12;
    localparam int CTRL_WRITE_ACK_IRQ_ENABLE_LSB = 0;
    localparam int CTRL_TOKEN_EN_BIT = 8;
    localparam int IST_ACK_LSB = 0;
    localparam int IST_TO_LSB = 4;

    // ==========================================================
    // Reset values
    localparam logic [NUM_CH-1:0] ACK_RCV_RST = 4'hf;
    localparam logic TOKEN_RST = 1'b1;
    localparam logic TOKEN_EN_RST = 1'b0;
    localparam logic [NUM_CH-1:0] WRITE_ACK_IRQ_ENABLE_RST = 4'h0;
    localparam logic [2*NUM_CH-1:0] IRQ_MASK_RST = 8'h00;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {FRM_WRITE, FRM_STREAM, FRM_TRIGGER} ilw_frame_kind_t;
    typedef enum logic {ST_IDLE, ST_WAIT_ACK} ilw_state_t;
    typedef struct packed {
        ilw_frame_kind_t kind;
        logic [CHW-1:0] chan;
    } ilw_frame_t;
endpackage

/* hw/ilw_sync.sv */
// Two-stage synchroniser with a rising-edge pulse for each input bit.
// Assumes inputs come from outside the pclk domain and stay high for
// at least two clock periods.
`timescale 1ns/1ps
module ilw_sync #(
    parameter int W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level_out,
    output logic [W-1:0] rise_out
);
    // ==========================================================
    // Per-bit synchroniser chain
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            logic prev_ff;
            // The first stage feeds only the second stage.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                    prev_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[i];
                    sync_ff <= meta_ff;
                    prev_ff <= sync_ff;
                end
            end
            assign level_out[i] = sync_ff;
            assign rise_out[i] = sync_ff & ~prev_ff;
        end
    endgenerate
endmodule

/* tb/ilw_peer_model.sv */
// Behavioural model of the peer link interface at the far end.
// Assumes the link_start pulse and link_frame of the write flow block on pclk.
`timescale 1ns/1ps
module ilw_peer_model #(
    parameter int ACK_DLY = 40,
    parameter int BUSY_CYC = 40,
    parameter int TRIG_DLY = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_start,
    input wire ilw_pkg::ilw_frame_t link_frame,
    input wire logic ack_en,
    input wire logic busy_req,
    output logic link_ack_in,
    output logic link_trig_in,
    output logic link_peer_busy_in
);
    import ilw_pkg::*;
    int ack_cnt;
    int ack_hold;
    int tok_cnt;
    int trig_hold;
    logic has_tok;

    // ==========================================================
    // Acknowledge
    // While ack_en is high, each data frame is answered after ACK_DLY cycles by a level held four cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_cnt <= 0;
            ack_hold <= 0;
            link_ack_in <= 1'b0;
        end else begin
            if (link_start && link_frame.kind != FRM_TRIGGER && ack_en) begin
                ack_cnt <= ACK_DLY;
            end else if (ack_cnt > 0) begin
                ack_cnt <= ack_cnt - 1;
            end
            if (ack_cnt == 1) begin
                ack_hold <= 4;
            end else if (ack_hold > 0) begin
                ack_hold <= ack_hold - 1;
            end
            link_ack_in <= (ack_cnt == 1) || (ack_hold > 1);
        end
    end

    // ==========================================================
    // Token
    // A received trigger hands over the token; the peer writes only while holding it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            has_tok <= 1'b0;
            tok_cnt <= 0;
            trig_hold <= 0;
            link_trig_in <= 1'b0;
            link_peer_busy_in <= 1'b0;
        end else begin
            if (trig_hold > 0) begin
                trig_hold <= trig_hold - 1;
            end
            if (trig_hold == 1) begin
                link_trig_in <= 1'b0;
            end
            if (link_start && link_frame.kind == FRM_TRIGGER) begin
                has_tok <= 1'b1;
                tok_cnt <= busy_req ? BUSY_CYC : TRIG_DLY;
                link_peer_busy_in <= busy_req;
            end else if (has_tok && tok_cnt > 1) begin
                tok_cnt <= tok_cnt - 1;
            end else if (has_tok) begin
                has_tok <= 1'b0;
                link_peer_busy_in <= 1'b0;
                link_trig_in <= 1'b1;
                trig_hold <= 3;
            end
        end
    end
endmodule

/* tb/tb.sv */
// Self-checking bench for the link write flow block over APB.
// Assumes ilw_pkg and the peer model; one 250 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb;
    import ilw_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic link_ack_in;
    logic link_trig_in;
    logic link_peer_busy_in;
    logic link_start;
    ilw_frame_t link_frame;
    logic irq;
    logic ack_en = 1'b1;
    logic busy_req = 1'b0;
    logic [31:0] v;
    logic e;
    int failures = 0;
    int compares = 0;
    int n_start = 0;
    int k;

    // Clock and start counter.
    always #2 pclk = ~pclk;
    always @(posedge pclk) if (link_start === 1'b1) n_start <= n_start + 1;

    ilw_link_write i_ilw_link_write (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_ack_in(link_ack_in), .link_trig_in(link_trig_in),
        .link_peer_busy_in(link_peer_busy_in), .link_start(link_start), .link_frame(link_frame), .irq(irq));
    ilw_peer_model i_ilw_peer_model (.pclk(pclk), .presetn(presetn), .link_start(link_start),
        .link_frame(link_frame), .ack_en(ack_en), .busy_req(busy_req), .link_ack_in(link_ack_in),
        .link_trig_in(link_trig_in), .link_peer_busy_in(link_peer_busy_in));

    // ==========================================================
    // Helpers
    // Prints the verdict and stops the run.
    task automatic end_sim();
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Counts one comparison and reports a mismatch.
    function automatic void check_val(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endfunction

    // One APB transfer; read data and error land in v and e.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            failures++;
            end_sim();
        end
    endtask

    // Reads until the masked bits are all set, under a bound.
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            apb(1'b0, a, 32'h0);
            if ((v & m) === m) break;
        end
        `CHK(v & m, m);
        if (i == n) end_sim();
    endtask

    // Waits for a frame start and checks its kind.
    task automatic wait_start(input ilw_frame_kind_t kd);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if (link_start === 1'b1) break;
        end
        `CHK(link_frame.kind, kd);
        if (i == 3000) end_sim();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(v & 32'h3f0f, 32'h020f);
        apb(1'b0, 12'h018, 32'h0);
        `CHK({e, v[30:0]}, 32'h8000_0000);
        // Write on channel 0, then an overlapping request on channel 1.
        apb(1'b1, OFF_CTRL, 32'h1);
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        apb(1'b1, OFF_CMD, 32'h1);
        wait_start(FRM_WRITE);
        `CHK(link_frame.chan, 0);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK({v[STA_BUSY_BIT], v[STA_ACK_LSB]}, 2'b10);
        k = n_start;
        apb(1'b1, OFF_CMD, 32'h2);
        apb(1'b0, OFF_ERR, 32'h0);
        `CHK(v[3:0], 4'h2);
        `CHK(irq, 1'b0);
        poll(OFF_STATUS, 32'h1, 200);
        `CHK(n_start, k);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        `CHK(v[7:0], 8'h21);
        `CHK(irq, 1'b1);
        apb(1'b1, OFF_IRQ_STAT, 32'hff);
        apb(1'b1, OFF_ERR, 32'hf);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        `CHK(v, 32'h0);
        `CHK(irq, 1'b0);
        // Streaming write on channel 3 with its ack interrupt disabled.
        apb(1'b1, OFF_CMD, 32'h80);
        wait_start(FRM_STREAM);
        `CHK(link_frame.chan, 3);
        poll(OFF_STATUS, 32'h8, 200);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        `CHK({irq, v[7:0]}, 9'h0);
        // Unanswered write on channel 2 runs into the timeout.
        @(posedge pclk);
        ack_en <= 1'b0;
        apb(1'b1, OFF_CMD, 32'h4);
        wait_start(FRM_WRITE);
        `CHK(link_frame.chan, 2);
        poll(OFF_ERR, 32'h4, 900);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        `CHK(v[7:0], 8'h40);
        apb(1'b1, OFF_IRQ_STAT, 32'hff);
        apb(1'b1, OFF_ERR, 32'hf);
        ack_en <= 1'b1;
        busy_req <= 1'b1;
        // Token mode: the token leaves while the command is still on the bus, so the write waits for its return.
        k = n_start;
        apb(1'b1, OFF_CTRL, 32'h101);
        apb(1'b1, OFF_CMD, 32'h1);
        `CHK(n_start - k, 1);
        `CHK(link_frame.kind, FRM_TRIGGER);
        wait_start(FRM_WRITE);
        `CHK({link_peer_busy_in, i_ilw_peer_model.has_tok}, 2'b00);
        wait_start(FRM_TRIGGER);
        end_sim();
    end
endmodule
